// *** segment_lcd_driver_timing_tb_top.sv ***
// Bench for the segment LCD driver: pins, pixel store, waveforms, flags, sleep.
// Assumes sld_driver and sld_glass_model are compiled before it.
`default_nettype none
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
end

module segment_lcd_driver_timing_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic         clk, nrst, disp_en, typeb, slp_en, sleep, pix_wr, ie, fclr, wclr;
    logic         osc_f, osc_s, osc_l, lad_en, lad_on, lad_b, flag, irq, write_error_flag, win;
    logic [1:0]   src, pa, pb, lad_pw;
    logic [2:0]   mux, lat;
    logic [3:0]   ps;
    logic [5:0]   addr;
    logic [7:0]   wdata, rdata, cdir, com_drv, com_oe;
    logic [15:0]  com_lvl;
    logic [59:0]  sdir, seg_drv, seg_oe;
    logic [63:0]  segen;
    logic [119:0] seg_lvl;
    int           dc0, dc1, sq0, sq1, error_cnt, comparisons;

    ////////////////////////////////////////////////////////////////
    sld_driver uut (
        .ref_clk_i(clk), .nrst_i(nrst), .clk_en_i(1'b1), .display_enable_i(disp_en),
        .multiplex_select_i(mux), .waveform_type_b_i(typeb), .clock_source_select_i(src),
        .frame_prescale_i(ps), .display_sleep_enable_i(slp_en), .segment_pin_enables_i(segen),
        .com_port_direction_control_i(cdir), .seg_port_direction_control_i(sdir), .sleep_i(sleep),
        .fast_internal_oscillator_i(osc_f), .secondary_oscillator_i(osc_s),
        .low_power_internal_oscillator_i(osc_l), .internal_ladder_enable_i(lad_en),
        .ladder_mode_a_interval_i(lat), .ladder_mode_a_power_i(pa), .ladder_mode_b_power_i(pb),
        .ladder_on_o(lad_on), .ladder_mode_b_o(lad_b), .ladder_power_o(lad_pw),
        .pix_wr_i(pix_wr), .pix_addr_i(addr), .pix_wdata_i(wdata), .pix_rdata_o(rdata),
        .frame_interrupt_enable_i(ie), .frame_flag_clr_i(fclr), .write_error_clr_i(wclr),
        .frame_interrupt_flag_o(flag), .frame_irq_o(irq), .write_error_flag_o(write_error_flag),
        .pixel_write_window_o(win), .com_drive_o(com_drv), .com_pin_oe_o(com_oe),
        .com_level_o(com_lvl), .seg_drive_o(seg_drv), .seg_pin_oe_o(seg_oe), .seg_level_o(seg_lvl)
    );

    sld_glass_model glass (
        .clk_i(clk), .com_level_i(com_lvl), .seg_level_i(seg_lvl),
        .dc0_o(dc0), .dc1_o(dc1), .sq0_o(sq0), .sq1_o(sq1)
    );

    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Source periods are whole clock multiples and toggle off the clock edge,
    // so every slot is equally long
    always #10 osc_f = ~osc_f;
    always #20 osc_s = ~osc_s;
    always #30 osc_l = ~osc_l;

    task automatic test_done;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        pix_wr <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge clk);
        pix_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        tick(2);
        `CHK(rdata, e)
    endtask

    task automatic poll(ref logic s, input logic v);
        int n;
        n = 0;
        // Let the updates of the current edge settle before the first look
        tick(0);
        while (s !== v && n < 9000) begin
            tick(1);
            n++;
        end
        `CHK(s, v)
    endtask

    // Waits until backplane 0 steps onto level v
    task automatic reach(input logic [1:0] v, output time t);
        logic [1:0] p;
        int         n;
        n = 0;
        p = com_lvl[1:0];
        tick(1);
        while (!(com_lvl[1:0] === v && p !== v) && n < 9000) begin
            p = com_lvl[1:0];
            tick(1);
            n++;
        end
        t = $time;
        `CHK(n < 9000, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_pins;
        logic [7:0] e;
        @(posedge clk);
        cdir  <= 8'h5a;
        sdir  <= 60'haaaaaaaaaaaaaaa;
        segen <= 64'h3000000000000003;
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            mux <= 3'(m);
            tick(2);
            e = 8'((16'h2 << m) - 16'h1) | ((m <= 3) ? 8'h30 : 8'h00);
            `CHK(com_drv[3:0], e[3:0])
            `CHK(com_drv[7:4], e[7:4])
            `CHK(com_oe, e | ~cdir)
        end
        `CHK(seg_drv, 60'h3)
        `CHK(seg_oe, 60'h3 | ~sdir)
        @(posedge clk);
        segen <= '1;
        $display("pin ownership test done");
    endtask

    task automatic t_store;
        for (int a = 0; a < 64; a++) wr(6'(a), 8'(a) ^ 8'ha5);
        for (int a = 0; a < 64; a++) rd(6'(a), 8'(a) ^ 8'ha5);
        for (int k = 0; k < 8; k++) wr(6'(k * 8), (k == 0) ? 8'h01 : 8'h00);
        $display("pixel store test done");
    endtask

    task automatic wave(input logic [2:0] m, input logic b, input logic [1:0] s, input logic [3:0] p);
        time t0, t1, ex;
        int  d0, d1, q;
        ex = ((m < 3'h2) ? 4 : m + 1) * 32 * (p + 1) * ((s == 2'h1) ? 40 : 60) * (b ? 2 : 1);
        // Static Type-A: backplane 0 rises once per slot
        if (m == 3'h0 && !b) ex = ex / 4;
        // Half Type-A: each backplane serves twice per frame
        if (m == 3'h1 && !b) ex = ex / 2;
        @(posedge clk);
        disp_en <= 1'b0;
        @(posedge clk);
        ps    <= p;
        mux   <= m;
        typeb <= b;
        src   <= s;
        fclr  <= 1'b1;
        ie    <= 1'b1;
        @(posedge clk);
        fclr    <= 1'b0;
        disp_en <= 1'b1;
        reach(2'h3, t0);
        reach(2'h3, t0);
        d0 = dc0;
        d1 = dc1;
        q  = sq0 - sq1;
        reach(2'h3, t1);
        `CHK(t1 - t0, ex)
        `CHK(dc0 - d0, 0)
        `CHK(dc1 - d1, 0)
        `CHK((sq0 - sq1) > q, 1'b1)
        `CHK(flag, b && m != 3'h0)
        $display("waveform test mux %0d type %0d done", m, b);
    endtask

    task automatic t_window;
        wave(3'h3, 1'b1, 2'h1, 4'h0);
        @(posedge clk);
        fclr <= 1'b1;
        @(posedge clk);
        fclr <= 1'b0;
        poll(flag, 1'b1);
        `CHK({irq, win}, 2'b11)
        wr(6'h01, 8'h5a);
        poll(win, 1'b0);
        `CHK(write_error_flag, 1'b0)
        wr(6'h02, 8'h3c);
        tick(0);
        `CHK(write_error_flag, 1'b1)
        rd(6'h02, 8'ha7);
        rd(6'h01, 8'h5a);
        @(posedge clk);
        wclr <= 1'b1;
        ie   <= 1'b0;
        @(posedge clk);
        wclr <= 1'b0;
        tick(0);
        `CHK({write_error_flag, irq}, 2'b00)
        $display("write window test done");
    endtask

    task automatic t_ladder;
        logic stay;
        @(posedge clk);
        lad_en <= 1'b1;
        pa     <= 2'h1;
        pb     <= 2'h2;
        tick(2);
        `CHK({lad_on, lad_b, lad_pw}, 4'b1110)
        @(posedge clk);
        lat <= 3'h7;
        poll(lad_b, 1'b0);
        `CHK(lad_pw, 2'h1)
        // Fast source: Mode B must hold for thousands of edges, not 9
        @(posedge clk);
        src <= 2'h0;
        poll(lad_b, 1'b1);
        stay = 1'b1;
        for (int k = 0; k < 200; k++) begin
            tick(1);
            stay &= lad_b;
        end
        `CHK(stay, 1'b1)
        @(posedge clk);
        src <= 2'h1;
        $display("ladder test done");
    endtask

    task automatic t_sleep;
        time t;
        reach(2'h0, t);
        @(posedge clk);
        slp_en <= 1'b1;
        sleep  <= 1'b1;
        tick(3);
        `CHK(seg_lvl, 120'h0)
        tick(600);
        `CHK(com_lvl, 16'h0)
        @(posedge clk);
        sleep <= 1'b0;
        reach(2'h3, t);
        @(posedge clk);
        slp_en <= 1'b0;
        sleep  <= 1'b1;
        reach(2'h3, t);
        wr(6'h03, 8'h00);
        tick(0);
        `CHK(write_error_flag, 1'b1)
        rd(6'h03, 8'ha6);
        $display("sleep test done");
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        {nrst, disp_en, typeb, slp_en, sleep, pix_wr, ie, fclr, wclr, lad_en} = '0;
        {osc_f, osc_s, osc_l, src, pa, pb, mux, lat, ps, addr, wdata} = '0;
        cdir  = 8'hff;
        sdir  = '1;
        segen = '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        tick(1);
        `CHK(com_drv, 8'h01)
        `CHK(seg_drv, 60'h0)
        t_pins;
        t_store;
        wave(3'h0, 1'b0, 2'h1, 4'h0);
        wave(3'h0, 1'b1, 2'h2, 4'h1);
        wave(3'h1, 1'b0, 2'h1, 4'h0);
        wave(3'h2, 1'b0, 2'h1, 4'h0);
        wave(3'h3, 1'b0, 2'h3, 4'h0);
        wave(3'h7, 1'b1, 2'h1, 4'h0);
        t_window;
        t_ladder;
        t_sleep;
        test_done;
    end

    // Whole run is near 23k cycles; a hang ends at 50k
    initial begin
        #500us;
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        test_done;
    end
endmodule

`default_nettype wire

// *** sld_consts.svh ***
// Constants of the segment LCD driver: reset values, divisors, drive levels.
// Assumes it is included by bare name and that the includer sets the nettype.
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH

`define SLD_MUX_RST         3'h0
`define SLD_SEGEN_RST       64'h0
`define SLD_MUX_HALF        3'h1
`define SLD_MUX_QUARTER     3'h3
`define SLD_STATIC_SLOTS_M1 3'h3
`define SLD_FAST_DIV        8192
`define SLD_SLOW_DIV        32
`define SLD_SRC_FAST        2'h0
`define SLD_SRC_SEC         2'h1
`define SLD_LVL_MIN         2'h0
`define SLD_LVL_LO          2'h1
`define SLD_LVL_HI          2'h2
`define SLD_LVL_MAX         2'h3
`define SLD_UPPER_COL       6'h3c

`endif

// *** sld_driver.sv ***
// Segment LCD driver: pin ownership, frame timing, zero-DC waveforms, pixel store.
// Assumes configuration ports come from logic on ref_clk_i; oscillator inputs are
// asynchronous and slower than half of ref_clk_i.
//
// Contract
// - multiplex field sets driven backplane line count
// - backplane pins ignore direction control, others obey
// - multiplex field resets to static drive
// - upper backplane pins act as segments when enabled, at quarter multiplex or less
// - segment enable bit claims pin over direction
// - segment enables all clear after reset
// - 64 byte pixel store, all bits storage
// - frame rate from prescale and multiplex factor
// - frame clock from one of three oscillators
// - zero DC; dark pixel gets higher RMS
// - Type-A inverts per slot, Type-B per frame
// - frame flag set after last row fetch
// - Type-B flag per frame pair, window writes
// - write outside window sets write error flag
// - no flag for Type-A or static Type-B
// - ladder interval splits Mode A and Mode B
// - display sleep stops drive at minimum level
// - sleep without display sleep keeps displaying, frozen
`include "sld_consts.svh"
`default_nettype none

module sld_driver
    import sld_pkg::*;
(
    // Clock, reset, enable
    input  wire logic          ref_clk_i,
    input  wire logic          nrst_i,
    input  wire logic          clk_en_i,
    // Configuration
    input  wire logic          display_enable_i,
    input  wire logic [2:0]    multiplex_select_i,
    input  wire logic          waveform_type_b_i,
    input  wire logic [1:0]    clock_source_select_i,
    input  wire logic [3:0]    frame_prescale_i,
    input  wire logic          display_sleep_enable_i,
    input  wire logic [63:0]   segment_pin_enables_i,
    input  wire logic [7:0]    com_port_direction_control_i,
    input  wire logic [59:0]   seg_port_direction_control_i,
    input  wire logic          sleep_i,
    // Oscillators
    input  wire logic          fast_internal_oscillator_i,
    input  wire logic          secondary_oscillator_i,
    input  wire logic          low_power_internal_oscillator_i,
    // Ladder control
    input  wire logic          internal_ladder_enable_i,
    input  wire logic [2:0]    ladder_mode_a_interval_i,
    input  wire logic [1:0]    ladder_mode_a_power_i,
    input  wire logic [1:0]    ladder_mode_b_power_i,
    output logic               ladder_on_o,
    output logic               ladder_mode_b_o,
    output logic [1:0]         ladder_power_o,
    // Pixel store access
    input  wire logic          pix_wr_i,
    input  wire logic [5:0]    pix_addr_i,
    input  wire logic [7:0]    pix_wdata_i,
    output logic [7:0]         pix_rdata_o,
    // Flags
    input  wire logic          frame_interrupt_enable_i,
    input  wire logic          frame_flag_clr_i,
    input  wire logic          write_error_clr_i,
    output logic               frame_interrupt_flag_o,
    output logic               frame_irq_o,
    output logic               write_error_flag_o,
    output logic               pixel_write_window_o,
    // Panel pins
    output logic [7:0]         com_drive_o,
    output logic [7:0]         com_pin_oe_o,
    output logic [15:0]        com_level_o,
    output logic [59:0]        seg_drive_o,
    output logic [59:0]        seg_pin_oe_o,
    output logic [119:0]       seg_level_o
);

    localparam logic [11:0] FAST_HALF_M1 = 12'(`SLD_FAST_DIV / 2 - 1);
    localparam logic [11:0] SLOW_HALF_M1 = 12'(`SLD_SLOW_DIV / 2 - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration capture and state
    logic [2:0]   cfg_mux_ff;
    logic [63:0]  cfg_segen_ff;
    sld_state_t   state_ff;
    sld_state_t   nxt_state;
    logic [2:0]   osc_meta_ff;
    logic [2:0]   osc_sync_ff;
    logic [2:0]   osc_old_ff;
    logic [11:0]  div_cnt_ff;
    logic [4:0]   pre_cnt_ff;
    logic [2:0]   slot_ff;
    logic         frame_odd_ff;
    logic         flag_ff;
    logic         write_error_flag_ff;
    logic         window_ff;
    logic [7:0]   pix_mem_ff [64];
    logic [7:0]   rdata_ff;
    logic [15:0]  com_lvl_ff;
    logic [119:0] seg_lvl_ff;

    wire running   = (state_ff == ST_RUN);
    wire deep_req  = sleep_i & display_sleep_enable_i;
    wire is_static = (cfg_mux_ff == 3'h0);
    wire type_b_mx = waveform_type_b_i & ~is_static;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF:   if (display_enable_i && !deep_req) nxt_state = ST_RUN;
            ST_RUN: begin
                if (!display_enable_i) nxt_state = ST_OFF;
                else if (deep_req) nxt_state = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (!display_enable_i) nxt_state = ST_OFF;
                else if (!sleep_i) nxt_state = ST_RUN;
            end
            default:  nxt_state = ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_mux_ff   <= `SLD_MUX_RST;
            cfg_segen_ff <= `SLD_SEGEN_RST;
            state_ff     <= ST_OFF;
        end else if (clk_en_i) begin
            cfg_mux_ff   <= multiplex_select_i;
            cfg_segen_ff <= segment_pin_enables_i;
            state_ff     <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame clock: synchronise oscillators, divide to half ticks, 2*(prescale+1) per slot
    // Half ticks let Type-A invert in mid-slot without changing the frame rate
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            osc_meta_ff <= 3'h0;
            osc_sync_ff <= 3'h0;
            osc_old_ff  <= 3'h0;
        end else if (clk_en_i) begin
            osc_meta_ff <= {low_power_internal_oscillator_i, secondary_oscillator_i,
                            fast_internal_oscillator_i};
            osc_sync_ff <= osc_meta_ff;
            osc_old_ff  <= osc_sync_ff;
        end
    end

    wire [2:0]  osc_rise = osc_sync_ff & ~osc_old_ff;
    wire        src_fast = (clock_source_select_i == `SLD_SRC_FAST);
    wire        src_edge = clk_en_i & running &
                           (src_fast ? osc_rise[0] :
                            (clock_source_select_i == `SLD_SRC_SEC) ? osc_rise[1] : osc_rise[2]);
    wire [11:0] half_m1  = src_fast ? FAST_HALF_M1 : SLOW_HALF_M1;
    wire        half_tick = src_edge & (div_cnt_ff >= half_m1);
    wire        pre_last  = (pre_cnt_ff == {frame_prescale_i, 1'b1});
    wire        slot_half = (pre_cnt_ff > {1'b0, frame_prescale_i});
    wire        slot_end  = half_tick & pre_last;
    wire [2:0]  slots_m1  = (cfg_mux_ff <= `SLD_MUX_HALF) ? `SLD_STATIC_SLOTS_M1 : cfg_mux_ff;
    wire        frame_end = slot_end & (slot_ff >= slots_m1);
    wire [2:0]  com_idx   = is_static ? 3'h0 :
                            (cfg_mux_ff == `SLD_MUX_HALF) ? {2'h0, slot_ff[0]} : slot_ff;
    wire        irq_evt   = slot_end & type_b_mx & frame_odd_ff &
                            (slot_ff == slots_m1 - 3'h1);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt_ff   <= 12'h000;
            pre_cnt_ff   <= 5'h00;
            slot_ff      <= 3'h0;
            frame_odd_ff <= 1'b0;
        end else if (clk_en_i && state_ff == ST_OFF) begin
            div_cnt_ff   <= 12'h000;
            pre_cnt_ff   <= 5'h00;
            slot_ff      <= 3'h0;
            frame_odd_ff <= 1'b0;
        end else if (src_edge) begin
            div_cnt_ff <= half_tick ? 12'h000 : div_cnt_ff + 12'h001;
            if (half_tick) begin
                pre_cnt_ff <= pre_last ? 5'h00 : pre_cnt_ff + 5'h01;
            end
            if (slot_end) begin
                slot_ff <= frame_end ? 3'h0 : slot_ff + 3'h1;
            end
            if (frame_end) begin
                frame_odd_ff <= ~frame_odd_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel store and write window
    // A refused write is dropped so a Type-B frame pair never sees changed data
    wire wr_allowed = ~sleep_i & (~running | ~type_b_mx | window_ff);
    wire pix_we     = clk_en_i & pix_wr_i & wr_allowed;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int k = 0; k < 64; k++) begin
                pix_mem_ff[k] <= 8'h00;
            end
            rdata_ff <= 8'h00;
        end else if (clk_en_i) begin
            if (pix_we) begin
                pix_mem_ff[pix_addr_i] <= pix_wdata_i;
            end
            rdata_ff <= pix_mem_ff[pix_addr_i];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_ff   <= 1'b0;
            write_error_flag_ff   <= 1'b0;
            window_ff <= 1'b0;
        end else if (clk_en_i) begin
            flag_ff   <= irq_evt | (flag_ff & ~frame_flag_clr_i);
            write_error_flag_ff   <= (pix_wr_i & ~wr_allowed) | (write_error_flag_ff & ~write_error_clr_i);
            window_ff <= irq_evt | (window_ff & ~frame_end & running & type_b_mx);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin ownership
    logic [7:0]  com_as_com;
    logic [7:0]  com_as_seg;
    logic [7:0]  com_act;
    logic [63:0] col_dark;
    sld_level_t  col_lvl [64];
    sld_level_t  com_lvl [8];
    wire         phase = waveform_type_b_i ? frame_odd_ff : slot_half;

    genvar gc;
    for (gc = 0; gc < 8; gc++) begin : g_com
        assign com_as_com[gc] = (3'(gc) <= cfg_mux_ff);
        if (gc >= 4) begin : g_upper
            assign com_as_seg[gc] = (cfg_mux_ff <= `SLD_MUX_QUARTER) &
                                    cfg_segen_ff[`SLD_UPPER_COL + 6'(gc - 4)];
        end else begin : g_lower
            assign com_as_seg[gc] = 1'b0;
        end
        assign com_act[gc] = com_as_com[gc] & (com_idx == 3'(gc));
        assign com_lvl[gc] = !running ? `SLD_LVL_MIN :
                             com_as_seg[gc] ? col_lvl[`SLD_UPPER_COL + 6'(gc - 4)] :
                             (is_static | com_act[gc]) ? (phase ? `SLD_LVL_MAX : `SLD_LVL_MIN) :
                             (phase ? `SLD_LVL_LO : `SLD_LVL_HI);
    end

    // Columns read the row of the active backplane
    genvar gs;
    for (gs = 0; gs < 64; gs++) begin : g_col
        assign col_dark[gs] = pix_mem_ff[{com_idx, 3'(gs / 8)}][gs % 8];
        assign col_lvl[gs]  = !running ? `SLD_LVL_MIN :
                              col_dark[gs] ? (phase ? `SLD_LVL_MIN : `SLD_LVL_MAX) :
                              is_static ? (phase ? `SLD_LVL_MAX : `SLD_LVL_MIN) :
                              (phase ? `SLD_LVL_HI : `SLD_LVL_LO);
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            com_lvl_ff <= 16'h0000;
            seg_lvl_ff <= 120'h0;
        end else if (clk_en_i) begin
            for (int i = 0; i < 8; i++) begin
                com_lvl_ff[2*i +: 2] <= com_lvl[i];
            end
            for (int j = 0; j < 60; j++) begin
                seg_lvl_ff[2*j +: 2] <= col_lvl[j];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Ladder Mode A covers the first interval edges of each half tick
    wire ladder_a = ({9'h000, ladder_mode_a_interval_i} > div_cnt_ff);

    assign com_drive_o            = com_as_com | com_as_seg;
    assign com_pin_oe_o           = com_drive_o | ~com_port_direction_control_i;
    assign seg_drive_o            = cfg_segen_ff[59:0];
    assign seg_pin_oe_o           = seg_drive_o | ~seg_port_direction_control_i;
    assign com_level_o            = com_lvl_ff;
    assign seg_level_o            = seg_lvl_ff;
    assign pix_rdata_o            = rdata_ff;
    assign frame_interrupt_flag_o = flag_ff;
    assign frame_irq_o            = flag_ff & frame_interrupt_enable_i;
    assign write_error_flag_o     = write_error_flag_ff;
    assign pixel_write_window_o   = wr_allowed;
    assign ladder_on_o            = internal_ladder_enable_i & running;
    assign ladder_mode_b_o        = ~ladder_a;
    assign ladder_power_o         = ladder_a ? ladder_mode_a_power_i : ladder_mode_b_power_i;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_sleep_entry;
        state_ff == ST_RUN && deep_req && display_enable_i && clk_en_i;
    endsequence

    sequence s_asleep;
        state_ff == ST_SLEEP && clk_en_i;
    endsequence

    a_reset_defaults: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> (cfg_mux_ff == 3'h0 && cfg_segen_ff == 64'h0))
        else $error("mux or segment enables not at reset value");

    a_com_count: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        com_as_com == 8'((9'h002 << cfg_mux_ff) - 9'h001))
        else $error("backplane count does not match multiplex field");

    a_upper_io: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (cfg_mux_ff <= 3'h3 && !cfg_segen_ff[60]) |-> (!com_drive_o[4] && com_pin_oe_o[4] ==
                                                        !com_port_direction_control_i[4]))
        else $error("upper backplane pin not returned to general I/O");

    a_seg_claim: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (seg_drive_o[0] && seg_port_direction_control_i[0]) |-> seg_pin_oe_o[0])
        else $error("claimed segment pin follows direction control");

    a_flag_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(flag_ff) |-> $past(waveform_type_b_i && cfg_mux_ff != 3'h0))
        else $error("frame flag raised in Type-A or static drive");

    a_flag_window: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(flag_ff) |-> (window_ff && $past(frame_odd_ff) && $past(slot_end)))
        else $error("frame flag without open write window");

    a_write_error_flag_set: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (clk_en_i && pix_wr_i && !wr_allowed) |=>
            (write_error_flag_ff && pix_mem_ff[$past(pix_addr_i)] == $past(pix_mem_ff[pix_addr_i])))
        else $error("refused write did not raise write error");

    a_sleep_enter: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        s_sleep_entry |=> (state_ff == ST_SLEEP))
        else $error("display sleep not entered at once");

    a_sleep_min: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        s_asleep |=> (com_level_o == 16'h0000 && seg_level_o == 120'h0))
        else $error("lines not at minimum level in display sleep");

    a_sleep_frozen: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (sleep_i && !display_sleep_enable_i && clk_en_i) |-> (!pix_we && nxt_state != ST_SLEEP))
        else $error("pixel data changed or display stopped in sleep");

    a_dark_rms: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (running && !is_static && com_act[0] && col_dark[0]) |-> ((com_lvl[0] ^ col_lvl[0]) == 2'h3))
        else $error("dark pixel not at full drive");

    a_slot_order: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (slot_end && !frame_end) |=> (slot_ff == $past(slot_ff) + 3'h1))
        else $error("backplane slots not ascending");

    a_frame_flip: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        frame_end |=> (frame_odd_ff != $past(frame_odd_ff) && slot_ff == 3'h0))
        else $error("frame parity did not invert at frame boundary");

endmodule

`default_nettype wire

// *** sld_glass_model.sv ***
// Glass model: running net DC and summed square on two pixels of backplane 0.
// Assumes drive levels are registered on clk_i; one sample per clock.
`default_nettype none

module sld_glass_model (
    // Bench clock
    input  wire logic         clk_i,
    // Panel drive
    input  wire logic [15:0]  com_level_i,
    input  wire logic [119:0] seg_level_i,
    // Running sums, columns 0 and 1
    output int                dc0_o,
    output int                dc1_o,
    output int                sq0_o,
    output int                sq1_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int v0;
    int v1;

    assign v0 = int'(com_level_i[1:0]) - int'(seg_level_i[1:0]);
    assign v1 = int'(com_level_i[1:0]) - int'(seg_level_i[3:2]);

    // Never cleared, as on real glass; the bench works on differences
    always_ff @(posedge clk_i) begin
        dc0_o <= dc0_o + v0;
        dc1_o <= dc1_o + v1;
        sq0_o <= sq0_o + v0 * v0;
        sq1_o <= sq1_o + v1 * v1;
    end
endmodule

`default_nettype wire

// *** sld_pkg.sv ***
// Types shared by the segment LCD driver.
// Assumes no other package of this block.
`default_nettype none

package sld_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_SLEEP} sld_state_t;
    typedef logic [1:0] sld_level_t;
endpackage

`default_nettype wire
